/* File: bws_pkg.sv */
`default_nettype none
package bws_pkg;

  // byte addresses on the register bus
  localparam logic [7:0] OFF_MEM_WIN = 8'h20;
  localparam logic [7:0] OFF_PF_WIN = 8'h24;
  localparam logic [7:0] OFF_PF_BASE_HI = 8'h28;
  localparam logic [7:0] OFF_PF_LIMIT_HI = 8'h2c;
  localparam logic [7:0] OFF_IO_HI = 8'h30;
  localparam logic [7:0] OFF_CAP_PTR = 8'h34;
  localparam logic [7:0] OFF_SEC_STS = 8'h38;
  localparam logic [7:0] OFF_CTRL = 8'h3c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h40;

  // secondary status bit positions
  localparam int STS_MDPE = 8;
  localparam int STS_STA = 11;
  localparam int STS_RTA = 12;
  localparam int STS_RMA = 13;
  localparam int STS_RSE = 14;
  localparam int STS_DPE = 15;
  localparam int STS_DEVSEL_LO = 9;

  // devsel encodings
  localparam logic [1:0] DEVSEL_FAST = 2'h0;
  localparam logic [1:0] DEVSEL_MED = 2'h1;
  localparam logic [1:0] DEVSEL_SLOW = 2'h2;

  // sticky bits, and the fixed read-only bits (66 MHz capable, medium)
  localparam logic [15:0] STS_W1C_MASK = 16'hf900;
  localparam logic [15:0] STS_FIXED = 16'h0220;

  // fixed read values
  localparam logic [3:0] ADDR_CAP_32 = 4'h0;
  localparam logic [31:0] UPPER_ZERO = 32'h0000_0000;
  localparam logic [15:0] IO_UPPER_ZERO = 16'h0000;
  localparam logic [7:0] CAP_PTR_VAL = 8'h70;

  // reset values
  localparam logic [11:0] WIN_FIELD_RST = 12'h000;
  localparam logic [15:0] STS_RST = 16'h0000;
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic CTRL_PERR_EN_RST = 1'b0;

  typedef enum logic [0:0] {
    BWS_BUS_IDLE = 1'b0,
    BWS_BUS_ACK = 1'b1
  } bws_bus_e;

  typedef struct packed {
    bws_bus_e bus_state;
    logic [31:0] rdata;
    logic [11:0] mem_base;
    logic [11:0] mem_limit;
    logic [11:0] pf_base;
    logic [11:0] pf_limit;
    logic [15:0] sts;
    logic [15:0] mask;
    logic perr_en;
    logic mem_hit;
    logic pf_hit;
  } bws_state_s;

  localparam bws_state_s BWS_RST = '{
    bus_state: BWS_BUS_IDLE,
    rdata: UPPER_ZERO,
    mem_base: WIN_FIELD_RST,
    mem_limit: WIN_FIELD_RST,
    pf_base: WIN_FIELD_RST,
    pf_limit: WIN_FIELD_RST,
    sts: STS_RST,
    mask: MASK_RST,
    perr_en: CTRL_PERR_EN_RST,
    mem_hit: 1'b0,
    pf_hit: 1'b0
  };

endpackage
`default_nettype wire

/* File: bws_regs.sv */
// Overview of operation
// - the master data parity flag never sets while parity response is off.
// - that flag sets only for a mastered transfer with response enabled and a read or write parity report.
// - each sticky status flag holds until a one is written to its bit.
// - the devsel timing field is read-only and reads as medium decode.
// - the signaled target-abort flag sets on a target abort or split completion abort, reset zero.
// - the received target-abort flag sets when a mastered transfer is target-aborted, reset zero.
// - the received master-abort flag sets when a mastered transfer master-aborts, reset zero.
// - the received system error flag sets whenever secondary system error is sampled, reset zero.
// - the detected parity flag sets on any uncorrectable secondary error whatever the enable.
// - the memory window hits when address bits 31:20 are at or above base and below limit.
// - the prefetchable window hits at or above base and below limit, taken as exclusive.
// - the low four bits of both prefetchable halves read as zero.
// - both prefetchable upper address words read as zero.
// - both halves of the i/o upper word read as zero.
// - the capability pointer reads as the first capability offset.
`timescale 1ns/1ps
`default_nettype none
module bws_regs
  import bws_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic sec_is_master,
  input wire logic sec_perr_drove_read,
  input wire logic sec_perr_seen_write,
  input wire logic sec_tabort_signaled,
  input wire logic sec_split_tabort,
  input wire logic sec_tabort_received,
  input wire logic sec_mabort_received,
  input wire logic sec_serr_sampled,
  input wire logic sec_uncorr_err,
  input wire logic [31:0] win_addr,
  output logic mem_win_hit,
  output logic pf_win_hit,
  output logic perr_resp_en,
  output logic irq
);

  bws_state_s r;
  bws_state_s n;
  logic req;
  logic wr_take;
  logic [31:0] wmask;
  logic [15:0] sts_set;
  logic [15:0] sts_clr;
  logic [15:0] sts_view;
  logic [31:0] rd_mux;
  logic [11:0] addr_hi;

  function automatic logic [11:0] upd12(input logic [11:0] o,
                                        input logic [11:0] d,
                                        input logic [11:0] m);
    upd12 = (o & ~m) | (d & m);
  endfunction

  assign req = avs_read | avs_write;
  // one wait state: readdata is captured first, then presented
  assign avs_waitrequest = req & (r.bus_state == BWS_BUS_IDLE);
  assign wr_take = avs_write & (r.bus_state == BWS_BUS_ACK);
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign addr_hi = win_addr[31:20];
  assign sts_view = r.sts | STS_FIXED;

  always_comb begin
    sts_set = STS_RST;
    sts_set[STS_MDPE] = sec_is_master & r.perr_en &
      (sec_perr_drove_read | sec_perr_seen_write);
    sts_set[STS_STA] = sec_tabort_signaled | sec_split_tabort;
    sts_set[STS_RTA] = sec_is_master & sec_tabort_received;
    sts_set[STS_RMA] = sec_is_master & sec_mabort_received;
    sts_set[STS_RSE] = sec_serr_sampled;
    sts_set[STS_DPE] = sec_uncorr_err;
  end

  always_comb begin
    sts_clr = STS_RST;
    if (wr_take && avs_address == OFF_SEC_STS) begin
      sts_clr = avs_writedata[15:0] & wmask[15:0];
    end
  end

  // reserved and fixed fields are rebuilt from constants on every read
  always_comb begin
    case (avs_address)
      OFF_MEM_WIN: rd_mux = {r.mem_limit, 4'h0, r.mem_base, 4'h0};
      OFF_PF_WIN: rd_mux = {r.pf_limit, ADDR_CAP_32,
                            r.pf_base, ADDR_CAP_32};
      OFF_PF_BASE_HI: rd_mux = UPPER_ZERO;
      OFF_PF_LIMIT_HI: rd_mux = UPPER_ZERO;
      OFF_IO_HI: rd_mux = {IO_UPPER_ZERO, IO_UPPER_ZERO};
      OFF_CAP_PTR: rd_mux = {24'h00_0000, CAP_PTR_VAL};
      OFF_SEC_STS: rd_mux = {16'h0000, sts_view};
      OFF_CTRL: rd_mux = {31'h0000_0000, r.perr_en};
      OFF_IRQ_MASK: rd_mux = {16'h0000, r.mask};
      default: rd_mux = UPPER_ZERO;
    endcase
  end

  always_comb begin
    n = r;
    case (r.bus_state)
      BWS_BUS_IDLE: begin
        if (req) begin
          n.bus_state = BWS_BUS_ACK;
          n.rdata = avs_read ? rd_mux : UPPER_ZERO;
        end
      end
      BWS_BUS_ACK: begin
        n.bus_state = BWS_BUS_IDLE;
      end
      default: begin
        n.bus_state = BWS_BUS_IDLE;
      end
    endcase
    if (wr_take) begin
      case (avs_address)
        OFF_MEM_WIN: begin
          n.mem_base = upd12(r.mem_base, avs_writedata[15:4],
                             wmask[15:4]);
          n.mem_limit = upd12(r.mem_limit, avs_writedata[31:20],
                              wmask[31:20]);
        end
        OFF_PF_WIN: begin
          n.pf_base = upd12(r.pf_base, avs_writedata[15:4],
                            wmask[15:4]);
          n.pf_limit = upd12(r.pf_limit, avs_writedata[31:20],
                             wmask[31:20]);
        end
        OFF_CTRL: begin
          if (avs_byteenable[0]) begin
            n.perr_en = avs_writedata[0];
          end
        end
        OFF_IRQ_MASK: begin
          n.mask = ((r.mask & ~wmask[15:0]) |
                    (avs_writedata[15:0] & wmask[15:0])) & STS_W1C_MASK;
        end
        default: begin
          n.perr_en = r.perr_en;
        end
      endcase
    end
    // a flag raised in the clearing cycle survives the clear
    n.sts = ((r.sts & ~sts_clr) | sts_set) & STS_W1C_MASK;
    n.mem_hit = (addr_hi >= r.mem_base) &&
                (addr_hi < r.mem_limit);
    n.pf_hit = (addr_hi >= r.pf_base) &&
               (addr_hi < r.pf_limit);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      r <= BWS_RST;
    end else begin
      r <= n;
    end
  end

  assign avs_readdata = r.rdata;
  assign mem_win_hit = r.mem_hit;
  assign pf_win_hit = r.pf_hit;
  assign perr_resp_en = r.perr_en;
  assign irq = |(r.sts & r.mask);

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  a_mdpe_gated: assert property (
    $rose(r.sts[STS_MDPE]) |-> $past(r.perr_en))
    else $error("master parity flag set with response disabled");

  a_mdpe_cause: assert property (
    (sec_is_master && r.perr_en && sec_perr_seen_write)
      |=> r.sts[STS_MDPE])
    else $error("master parity flag missed a write parity report");

  a_flag_hold: assert property (
    r.sts[STS_DPE] && !(wr_take && avs_address == OFF_SEC_STS &&
      avs_writedata[STS_DPE] && avs_byteenable[1]) |=> r.sts[STS_DPE])
    else $error("parity flag lost without a write of one");

  a_devsel_read: assert property (
    (avs_read && !avs_waitrequest && avs_address == OFF_SEC_STS)
      |-> avs_readdata[10:9] == DEVSEL_MED)
    else $error("devsel timing field not medium");

  a_sta_set: assert property (
    sec_split_tabort |=> r.sts[STS_STA])
    else $error("signaled abort flag missed split abort");

  a_rta_set: assert property (
    (sec_is_master && sec_tabort_received) |=> r.sts[STS_RTA])
    else $error("received target abort flag missed");

  a_rma_set: assert property (
    (sec_is_master && sec_mabort_received) |=> r.sts[STS_RMA])
    else $error("received master abort flag missed");

  a_rse_set: assert property (
    sec_serr_sampled |=> r.sts[STS_RSE])
    else $error("system error flag missed");

  a_dpe_set: assert property (
    (sec_uncorr_err && !r.perr_en) |=> r.sts[STS_DPE])
    else $error("detected parity flag gated by enable");

  a_mem_hit: assert property (
    mem_win_hit |-> ($past(addr_hi) < $past(r.mem_limit)) &&
      ($past(addr_hi) >= $past(r.mem_base)))
    else $error("memory window hit outside base and limit");

  a_pf_low_zero: assert property (
    (avs_read && !avs_waitrequest && avs_address == OFF_PF_WIN)
      |-> avs_readdata[3:0] == 4'h0 && avs_readdata[19:16] == 4'h0)
    else $error("prefetch address capability bits not zero");

  a_upper_zero: assert property (
    (avs_read && !avs_waitrequest &&
      (avs_address == OFF_PF_BASE_HI || avs_address == OFF_IO_HI))
      |-> avs_readdata == 32'h0000_0000)
    else $error("upper address word not zero");

  a_cap_ptr: assert property (
    (avs_read && !avs_waitrequest && avs_address == OFF_CAP_PTR)
      |-> avs_readdata == 32'h0000_0070)
    else $error("capability pointer wrong");

  a_pf_hit: assert property (
    pf_win_hit |-> ($past(addr_hi) < $past(r.pf_limit)) &&
      ($past(addr_hi) >= $past(r.pf_base)))
    else $error("prefetch window hit outside base and limit");

  // the miss checks catch a decode that is stuck low
  a_mem_miss: assert property (
    !mem_win_hit |-> !(($past(addr_hi) < $past(r.mem_limit)) &&
      ($past(addr_hi) >= $past(r.mem_base))))
    else $error("memory window missed an address inside it");

  a_pf_miss: assert property (
    !pf_win_hit |-> !(($past(addr_hi) < $past(r.pf_limit)) &&
      ($past(addr_hi) >= $past(r.pf_base))))
    else $error("prefetch window missed an address inside it");

  a_mdpe_off: assert property (
    !r.perr_en |=> !$rose(r.sts[STS_MDPE]))
    else $error("master parity flag rose while response is off");

  a_mdpe_read: assert property (
    (sec_is_master && r.perr_en && sec_perr_drove_read)
      |=> r.sts[STS_MDPE])
    else $error("master parity flag missed a read parity report");

  a_mdpe_master: assert property (
    $rose(r.sts[STS_MDPE]) |-> $past(sec_is_master))
    else $error("master parity flag set for a transfer not mastered");

  a_sta_target: assert property (
    sec_tabort_signaled |=> r.sts[STS_STA])
    else $error("signaled abort flag missed target abort");

  a_rta_cause: assert property (
    $rose(r.sts[STS_RTA]) |->
      $past(sec_is_master && sec_tabort_received))
    else $error("received target abort flag set without cause");

  a_rma_cause: assert property (
    $rose(r.sts[STS_RMA]) |->
      $past(sec_is_master && sec_mabort_received))
    else $error("received master abort flag set without cause");

  a_rse_cause: assert property (
    $rose(r.sts[STS_RSE]) |-> $past(sec_serr_sampled))
    else $error("system error flag set without cause");

  a_dpe_any: assert property (
    sec_uncorr_err |=> r.sts[STS_DPE])
    else $error("detected parity flag missed an error");

  a_dpe_cause: assert property (
    $rose(r.sts[STS_DPE]) |-> $past(sec_uncorr_err))
    else $error("detected parity flag set without cause");

  // the clear only wins when no new event arrives in the same cycle
  a_sts_clear: assert property (
    (wr_take && avs_address == OFF_SEC_STS && avs_byteenable[1] &&
      avs_writedata[STS_RSE] && !sec_serr_sampled) |=> !r.sts[STS_RSE])
    else $error("system error flag survived a write of one");

  a_sts_zero_hold: assert property (
    (!r.sts[STS_RMA] && !(sec_is_master && sec_mabort_received))
      |=> !r.sts[STS_RMA])
    else $error("master abort flag set with no event");

  a_sts_reserved: assert property (
    (r.sts & ~STS_W1C_MASK) == 16'h0000)
    else $error("reserved status bit holds a one");

  a_mask_reserved: assert property (
    (r.mask & ~STS_W1C_MASK) == 16'h0000)
    else $error("reserved mask bit holds a one");

  a_limit_hi_zero: assert property (
    (avs_read && !avs_waitrequest && avs_address == OFF_PF_LIMIT_HI)
      |-> avs_readdata == 32'h0000_0000)
    else $error("prefetch limit upper word not zero");

  a_mem_low_zero: assert property (
    (avs_read && !avs_waitrequest && avs_address == OFF_MEM_WIN)
      |-> avs_readdata[3:0] == 4'h0 && avs_readdata[19:16] == 4'h0)
    else $error("memory window reserved bits not zero");

  a_mem_write: assert property (
    (wr_take && avs_address == OFF_MEM_WIN && avs_byteenable == 4'hf)
      |=> r.mem_base == $past(avs_writedata[15:4]) &&
        r.mem_limit == $past(avs_writedata[31:20]))
    else $error("memory window write not taken");

  a_pf_write: assert property (
    (wr_take && avs_address == OFF_PF_WIN && avs_byteenable == 4'hf)
      |=> r.pf_base == $past(avs_writedata[15:4]) &&
        r.pf_limit == $past(avs_writedata[31:20]))
    else $error("prefetch window write not taken");

  a_perr_write: assert property (
    (wr_take && avs_address == OFF_CTRL && avs_byteenable[0])
      |=> perr_resp_en == $past(avs_writedata[0]))
    else $error("parity response enable write not taken");

  // exactly one wait state, so masters never see a longer stall
  a_wait_one: assert property (
    (req && r.bus_state == BWS_BUS_IDLE) |=> !avs_waitrequest)
    else $error("request stalled for more than one cycle");

  a_ack_idle: assert property (
    r.bus_state == BWS_BUS_ACK |=> r.bus_state == BWS_BUS_IDLE)
    else $error("bus acknowledge lasted more than one cycle");

endmodule
`default_nettype wire

/* File: bws_sec_agent.sv */
`timescale 1ns/1ps
`default_nettype none
module bws_sec_agent (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] ev_req,
  input wire logic mst_req,
  output logic sec_is_master,
  output logic [7:0] ev
);
  // each event flag is ev_req registered one cycle later and lasts as long as ev_req is held
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ev <= 8'h00;
      sec_is_master <= 1'b0;
    end else begin
      ev <= ev_req;
      sec_is_master <= mst_req;
    end
  end
endmodule
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
  err_total++; $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module testbench
  import bws_pkg::*;
;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0, avs_write = 1'b0, mst_req = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000, win_addr = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hf;
  logic avs_waitrequest, mem_win_hit, pf_win_hit, perr_resp_en, irq;
  logic sec_is_master, wq;
  logic [7:0] ev, ev_req = 8'h00;
  logic [31:0] avs_readdata, rq, q;
  int err_total = 0, num_checks = 0;
  always #2 clock = ~clock;
  // snapshot half a cycle early so the rising edge sees settled values
  always @(negedge clock) begin
    wq <= avs_waitrequest;
    rq <= avs_readdata;
  end
  bws_sec_agent bws_sec_agent_inst (.clock(clock), .sys_rst(sys_rst),
    .ev_req(ev_req), .mst_req(mst_req), .sec_is_master(sec_is_master),
    .ev(ev));
  bws_regs bws_regs_inst (.clock(clock), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sec_is_master(sec_is_master), .sec_perr_drove_read(ev[0]),
    .sec_perr_seen_write(ev[1]), .sec_tabort_signaled(ev[2]),
    .sec_split_tabort(ev[3]), .sec_tabort_received(ev[4]),
    .sec_mabort_received(ev[5]), .sec_serr_sampled(ev[6]),
    .sec_uncorr_err(ev[7]), .win_addr(win_addr), .mem_win_hit(mem_win_hit),
    .pf_win_hit(pf_win_hit), .perr_resp_en(perr_resp_en), .irq(irq));
  task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    // no cycle budget here: a slave that never answers is the watchdog's
    do begin
      @(posedge clock);
    end while (wq !== 1'b0);
    q = rq;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    `CHK(q, e)
  endtask
  task automatic fire(input logic [7:0] e, input logic m);
    ev_req <= e;
    mst_req <= m;
    @(posedge clock);
    ev_req <= 8'h00;
    mst_req <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  function automatic logic [15:0] sts_exp(logic [7:0] e, logic m, logic p);
    sts_exp = STS_FIXED;
    sts_exp[STS_MDPE] = m & p & (e[0] | e[1]);
    sts_exp[STS_STA] = e[2] | e[3];
    sts_exp[STS_RTA] = m & e[4];
    sts_exp[STS_RMA] = m & e[5];
    sts_exp[STS_RSE] = e[6];
    sts_exp[STS_DPE] = e[7];
  endfunction
  function automatic logic hit(logic [31:0] w, logic [11:0] t);
    hit = (t >= w[15:4]) && (t < w[31:20]);
  endfunction
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clock);
    err_total++;
    wrap_up();
  end
  initial begin
    logic [31:0] r, b, l, w, wm, fx;
    logic [11:0] tp;
    logic [7:0] o, e;
    int i, k, p;
    void'($urandom(32'h447b_cc20));
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    for (i = 0; i < 6; i++) begin
      o = 8'h20 + 8'(4 * i);
      wm = (i < 2) ? 32'hfff0_fff0 : UPPER_ZERO;
      fx = (i == 5) ? {24'h00_0000, CAP_PTR_VAL} : UPPER_ZERO;
      chk_rd(o, fx);
      for (k = 0; k < 2; k++) begin
        r = k ? $urandom : 32'hffff_ffff;
        bus(1'b1, o, r);
        chk_rd(o, (r & wm) | fx);
      end
    end
    bus(1'b1, 8'h44, 32'hffff_ffff);
    chk_rd(8'h44, UPPER_ZERO);
    chk_rd(OFF_SEC_STS, {16'h0000, STS_FIXED});
    $display("test register map done");
    for (k = 0; k < 6; k++) begin
      b = k ? $urandom : 32'h2000_1000;
      l = k ? $urandom : 32'h0010_0000;
      bus(1'b1, OFF_MEM_WIN, b);
      bus(1'b1, OFF_PF_WIN, l);
      for (i = 0; i < 8; i++) begin
        w = i[2] ? l : b;
        tp = (i[1] ? w[31:20] : w[15:4]) - 12'(i[0]);
        win_addr <= {tp, 20'($urandom)};
        @(posedge clock);
        @(negedge clock);
        `CHK(mem_win_hit, hit(b, tp))
        `CHK(pf_win_hit, hit(l, tp))
        @(posedge clock);
      end
    end
    $display("test windows done");
    for (p = 0; p < 2; p++) begin
      bus(1'b1, OFF_CTRL, 32'(p));
      for (k = 0; k < 20; k++) begin
        e = (k < 16) ? 8'h01 << k[2:0] : 8'($urandom);
        bus(1'b1, OFF_SEC_STS, 32'h0000_ffff);
        fire(e, k[3]);
        `CHK(perr_resp_en, 1'(p))
        r = {16'h0000, sts_exp(e, k[3], 1'(p))};
        chk_rd(OFF_SEC_STS, r);
        chk_rd(OFF_SEC_STS, r);
      end
    end
    $display("test status events done");
    fire(8'hff, 1'b1);
    bus(1'b1, OFF_SEC_STS, 32'h0000_0000);
    chk_rd(OFF_SEC_STS, 32'h0000_fb20);
    `CHK(irq, 1'b0)
    bus(1'b1, OFF_IRQ_MASK, 32'h0000_0800);
    `CHK(irq, 1'b1)
    // bit 11 is left set so the masked source alone keeps irq up
    r = $urandom & 32'h0000_f100;
    bus(1'b1, OFF_SEC_STS, r);
    chk_rd(OFF_SEC_STS, 32'h0000_fb20 & ~r);
    `CHK(irq, 1'b1)
    bus(1'b1, OFF_SEC_STS, 32'h0000_0800);
    `CHK(irq, 1'b0)
    $display("test sticky and interrupt done");
    wrap_up();
  end
endmodule
`default_nettype wire
